//--- bsw_top.sv
`timescale 1ns/10ps
// Overview of operation
// - Flag minimum system voltage regulation
// - Flag which input limit is regulating
// - Reduce charge while an input limit acts
// - Enter supplement on system drop below battery
// - Leave supplement, switch off when depleted
// - Disable bit opens switch, optionally delayed
// - Adapter or cleared bit ends shipping
// - Register reset restores defaults, ends shipping
// - Deglitched button press ends shipping
// - Long button press power-cycles the switch
// - Reset enable bit zero inhibits button reset
// - Power good only when all source checks
// - Monitor field 11 disables indicator
// - Indicator low while charging
// - Indicator released when done, sleep, disabled
// - Indicator blinks during suspend faults
module bsw_top #(
  parameter int unsigned SHIP_DLY_CYC = bsw_pkg::BSW_SHIP_DLY_CYC,
  parameter int unsigned DEGLITCH_CYC = bsw_pkg::BSW_DEGLITCH_CYC,
  parameter int unsigned RST_HOLD_CYC = bsw_pkg::BSW_RST_HOLD_CYC,
  parameter int unsigned RST_OFF_CYC = bsw_pkg::BSW_RST_OFF_CYC,
  parameter int unsigned BLINK_HALF_CYC = bsw_pkg::BSW_BLINK_HALF_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bsw_pkg::BSW_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog comparators and push button.
  input wire bsw_pkg::bsw_sense_t sense,
  input wire logic push_button_input,
  // Power stage controls.
  output logic battery_switch_on,
  output logic supplement_mode,
  output logic charge_reduce,
  // Indicators.
  output logic power_good_pin_n,
  output logic stat_out,
  output logic stat_oe_n,
  output logic irq
);
  import bsw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation.
  bsw_sense_t sn;
  logic btn_low;
  logic [31:0] btn_cnt;
  logic [31:0] dly_cnt;
  logic [31:0] off_cnt;

  bsw_sync #(.W($bits(bsw_sense_t) + 1)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    // The button is inverted before the synchroniser, so its reset value reads as released.
    .din({sense, !push_button_input}),
    .dout({sn, btn_low})
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB registers.
  bsw_ctrl_t ctrl;
  bsw_status_t status;
  bsw_state_t state;
  bsw_state_t next_state;
  logic [BSW_INT_W-1:0] int_st;
  logic [BSW_INT_W-1:0] int_mask;
  logic [BSW_INT_W-1:0] ev;
  logic [BSW_INT_W-1:0] next_int_st;
  logic setup;
  logic wr;
  logic wr_ctrl;
  logic reg_rst;
  logic ship_req;
  logic ship_exit_clr;
  logic btn_evt;
  logic btn_armed;
  logic btn_rst_go;
  logic next_pg;
  logic next_supp;
  logic blink;
  logic [31:0] blink_cnt;
  logic suspend;
  logic chg_active;

  assign setup = psel && !penable;
  assign wr = psel && penable && pready && pwrite;
  assign wr_ctrl = wr && (paddr == BSW_CTRL_OFS);
  assign reg_rst = wr_ctrl && pwdata[BSW_CTRL_REGRST_POS];
  assign ship_req = wr_ctrl && !reg_rst && pwdata[BSW_CTRL_DIS_POS] && !ctrl.battery_switch_disable_bit;

  // Answer one cycle after setup: zero wait states.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= 1'b0;
        case (paddr)
          BSW_CTRL_OFS: prdata <= {26'h0000000, ctrl};
          BSW_STATUS_OFS: prdata <= {23'h000000, status};
          BSW_INT_STATUS_OFS: prdata <= {27'h0000000, int_st};
          BSW_INT_MASK_OFS: prdata <= {27'h0000000, int_mask};
          default: begin
            prdata <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // Control bits; the register-reset bit itself is never stored.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= BSW_CTRL_RESET;
    end else if (reg_rst) begin
      ctrl <= BSW_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= {pwdata[BSW_CTRL_MON_POS +: 2], 1'b0, pwdata[BSW_CTRL_RSTEN_POS:BSW_CTRL_DIS_POS]};
    end else if (ship_exit_clr) begin
      ctrl.battery_switch_disable_bit <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_mask <= BSW_INT_RESET;
    end else if (reg_rst) begin
      int_mask <= BSW_INT_RESET;
    end else if (wr && paddr == BSW_INT_MASK_OFS) begin
      int_mask <= pwdata[BSW_INT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Battery switch sequencer.
  // button low timer
  bsw_timer #(.W(32)) u_btn (
    .clk(clk),
    .reset_n(reset_n),
    .run(btn_low),
    .limit(32'(RST_HOLD_CYC)),
    .count(btn_cnt)
  );

  bsw_timer #(.W(32)) u_dly (
    .clk(clk),
    .reset_n(reset_n),
    .run(state == BSW_ST_SHIP_WAIT),
    .limit(32'(SHIP_DLY_CYC)),
    .count(dly_cnt)
  );

  bsw_timer #(.W(32)) u_off (
    .clk(clk),
    .reset_n(reset_n),
    .run(state == BSW_ST_RST_OFF),
    .limit(32'(RST_OFF_CYC)),
    .count(off_cnt)
  );

  assign btn_evt = btn_low && (btn_cnt == 32'(DEGLITCH_CYC));
  assign btn_rst_go = btn_low && btn_armed && (btn_cnt == 32'(RST_HOLD_CYC)) && !sn.adapter_present
                      && !ctrl.battery_switch_disable_bit && ctrl.button_reset_enable_bit;
  assign ship_exit_clr = ((state == BSW_ST_SHIP) && (sn.adapter_present || btn_evt))
                         || ((state == BSW_ST_SHIP_WAIT) && sn.adapter_present);

  // One power cycle per press: the button must be released to re-arm.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      btn_armed <= 1'b0;
    end else if (!btn_low) begin
      btn_armed <= 1'b1;
    end else if (btn_rst_go && state == BSW_ST_ON) begin
      btn_armed <= 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      BSW_ST_ON: begin
        if (ship_req) begin
          next_state = pwdata[BSW_CTRL_DLY_POS] ? BSW_ST_SHIP_WAIT : BSW_ST_SHIP;
        end else if (btn_rst_go) begin
          next_state = BSW_ST_RST_OFF;
        end
      end
      BSW_ST_SHIP_WAIT: begin
        if (!ctrl.battery_switch_disable_bit || sn.adapter_present) begin
          next_state = BSW_ST_ON;
        end else if (dly_cnt == 32'(SHIP_DLY_CYC)) begin
          next_state = BSW_ST_SHIP;
        end
      end
      BSW_ST_SHIP: begin
        if (!ctrl.battery_switch_disable_bit || sn.adapter_present || btn_evt) begin
          next_state = BSW_ST_ON;
        end
      end
      BSW_ST_RST_OFF: begin
        if (off_cnt == 32'(RST_OFF_CYC)) begin
          next_state = BSW_ST_ON;
        end
      end
      default: next_state = BSW_ST_ON;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= BSW_ST_ON;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    next_supp = supplement_mode;
    if (sn.bat_depleted || !(next_state == BSW_ST_ON || next_state == BSW_ST_SHIP_WAIT)) begin
      next_supp = 1'b0;
    end else if (sn.bat_above_min ? sn.sys_drop_180 : sn.sys_drop_45) begin
      next_supp = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      supplement_mode <= 1'b0;
      battery_switch_on <= 1'b0;
      charge_reduce <= 1'b0;
    end else begin
      supplement_mode <= next_supp;
      battery_switch_on <= (next_state == BSW_ST_ON || next_state == BSW_ST_SHIP_WAIT) && !sn.bat_depleted;
      charge_reduce <= sn.input_voltage_limit || sn.input_current_limit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, power good and interrupts.
  // all good-source checks
  assign next_pg = sn.pg_above_uvlo && sn.pg_above_bat && sn.pg_below_ovp && sn.pg_load_ok && sn.pg_detect_done;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status <= '0;
      power_good_pin_n <= 1'b1;
    end else begin
      status.min_system_regulation_flag <= sn.sys_at_min;
      status.input_voltage_limit_flag <= sn.input_voltage_limit;
      status.input_current_limit_flag <= sn.input_current_limit;
      status.power_good_flag <= next_pg;
      status.supplement <= next_supp;
      status.switch_on <= (next_state == BSW_ST_ON || next_state == BSW_ST_SHIP_WAIT) && !sn.bat_depleted;
      status.ship_mode <= next_state == BSW_ST_SHIP;
      status.state <= next_state;
      power_good_pin_n <= !next_pg;
    end
  end

  always_comb begin
    ev = '0;
    ev[BSW_EV_PG] = next_pg && !status.power_good_flag;
    ev[BSW_EV_SHIP_EXIT] = (state == BSW_ST_SHIP || state == BSW_ST_SHIP_WAIT) && next_state == BSW_ST_ON;
    ev[BSW_EV_BTN_RST] = state == BSW_ST_ON && next_state == BSW_ST_RST_OFF;
    ev[BSW_EV_DPM] = (sn.input_voltage_limit && !status.input_voltage_limit_flag)
                     || (sn.input_current_limit && !status.input_current_limit_flag);
    ev[BSW_EV_SUPP] = next_supp && !supplement_mode;
    // A new event wins over a write-one-to-clear in the same cycle.
    next_int_st = int_st;
    if (reg_rst) begin
      next_int_st = BSW_INT_RESET;
    end else if (wr && paddr == BSW_INT_STATUS_OFS) begin
      next_int_st = int_st & ~pwdata[BSW_INT_W-1:0];
    end
    next_int_st = next_int_st | ev;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_st <= BSW_INT_RESET;
      irq <= 1'b0;
    end else begin
      int_st <= next_int_st;
      irq <= |(next_int_st & int_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Charge indicator.
  // half-period divider
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      blink_cnt <= 32'h00000000;
      blink <= 1'b0;
    end else if (blink_cnt == 32'(BLINK_HALF_CYC - 1)) begin
      blink_cnt <= 32'h00000000;
      blink <= !blink;
    end else begin
      blink_cnt <= blink_cnt + 32'h00000001;
    end
  end

  assign suspend = sn.susp_ovp || sn.susp_ts || sn.susp_timer || sn.susp_sysovp || sn.boost_ts_fault;
  // Completion, sleep and disable all release the indicator even if charging is still reported.
  assign chg_active = sn.charging && !sn.charge_done && !sn.sleep_mode && !sn.charge_disabled;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_out <= 1'b0;
      stat_oe_n <= 1'b1;
    end else begin
      stat_out <= 1'b0;
      if (ctrl.charge_monitor_field == BSW_MON_OFF) begin
        stat_oe_n <= 1'b1;
      end else if (suspend) begin
        stat_oe_n <= blink;
      end else if (chg_active) begin
        stat_oe_n <= 1'b0;
      end else begin
        stat_oe_n <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_MIN_FLAG: assert property (sn.sys_at_min |=> status.min_system_regulation_flag)
    else $error("min system flag not set");
  AST_DPM_FLAG: assert property (##1 status.input_current_limit_flag == $past(sn.input_current_limit))
    else $error("input current flag wrong");
  AST_REDUCE: assert property ((sn.input_voltage_limit || sn.input_current_limit) |=> charge_reduce)
    else $error("charge not reduced");
  AST_SUPP_IN: assert property (state == BSW_ST_ON && next_state == BSW_ST_ON && !sn.bat_depleted
                                && (sn.bat_above_min ? sn.sys_drop_180 : sn.sys_drop_45)
                                |=> supplement_mode)
    else $error("supplement not entered");
  AST_DEPLETE: assert property (sn.bat_depleted |=> !supplement_mode && !battery_switch_on)
    else $error("depleted battery not isolated");
  AST_SHIP_NOW: assert property (state == BSW_ST_ON && ship_req && !pwdata[BSW_CTRL_DLY_POS]
                                 |=> state == BSW_ST_SHIP && !battery_switch_on)
    else $error("immediate shipping failed");
  AST_SHIP_ADP: assert property (state == BSW_ST_SHIP && sn.adapter_present |=> state == BSW_ST_ON)
    else $error("adapter did not end shipping");
  AST_REG_RST: assert property (reg_rst |=> ctrl == BSW_CTRL_RESET && int_mask == BSW_INT_RESET)
    else $error("register reset incomplete");
  AST_BTN_EXIT: assert property (state == BSW_ST_SHIP && btn_evt |=> state == BSW_ST_ON)
    else $error("button did not end shipping");
  AST_RST_OFF: assert property (state == BSW_ST_RST_OFF && off_cnt == 32'(RST_OFF_CYC)
                                |=> state == BSW_ST_ON)
    else $error("switch not reclosed");
  AST_RST_INH: assert property (state == BSW_ST_ON && !ctrl.button_reset_enable_bit
                                |=> state != BSW_ST_RST_OFF)
    else $error("button reset not inhibited");
  AST_PG: assert property (power_good_pin_n == !status.power_good_flag)
    else $error("power good pin and flag disagree");
  AST_MON_OFF: assert property (ctrl.charge_monitor_field == BSW_MON_OFF |=> stat_oe_n)
    else $error("indicator not disabled");
  AST_CHG_LOW: assert property (ctrl.charge_monitor_field != BSW_MON_OFF && !suspend && chg_active
                                |=> !stat_oe_n)
    else $error("indicator not low while charging");
  AST_RELEASE: assert property (!suspend && !chg_active |=> stat_oe_n)
    else $error("indicator not released");
  AST_BLINK: assert property (ctrl.charge_monitor_field != BSW_MON_OFF && suspend |=> stat_oe_n == $past(blink))
    else $error("indicator not blinking");
  AST_DIV: assert property ($changed(blink) |-> $past(blink_cnt) == 32'(BLINK_HALF_CYC - 1))
    else $error("blink divider period wrong");

  COV_SHIP: cover property (state == BSW_ST_SHIP_WAIT ##1 state == BSW_ST_SHIP);
  COV_BTN_RST: cover property (state == BSW_ST_RST_OFF ##1 state == BSW_ST_ON);
  COV_SUPP: cover property ($rose(supplement_mode));
  COV_BLINK: cover property (suspend && $changed(stat_oe_n));

endmodule : bsw_top

//--- bsw_pkg.sv
package bsw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the APB.
  localparam int BSW_AW = 8;
  localparam logic [7:0] BSW_CTRL_OFS = 8'h00;
  localparam logic [7:0] BSW_STATUS_OFS = 8'h04;
  localparam logic [7:0] BSW_INT_STATUS_OFS = 8'h08;
  localparam logic [7:0] BSW_INT_MASK_OFS = 8'h0c;

  // Control register fields.
  localparam int BSW_CTRL_DIS_POS = 0;
  localparam int BSW_CTRL_DLY_POS = 1;
  localparam int BSW_CTRL_RSTEN_POS = 2;
  localparam int BSW_CTRL_REGRST_POS = 3;
  localparam int BSW_CTRL_MON_POS = 4;
  localparam logic [5:0] BSW_CTRL_RESET = 6'h04;
  localparam logic [1:0] BSW_MON_OFF = 2'h3;

  // Interrupt event bits.
  localparam int BSW_INT_W = 5;
  localparam int BSW_EV_PG = 0;
  localparam int BSW_EV_SHIP_EXIT = 1;
  localparam int BSW_EV_BTN_RST = 2;
  localparam int BSW_EV_DPM = 3;
  localparam int BSW_EV_SUPP = 4;
  localparam logic [4:0] BSW_INT_RESET = 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int unsigned BSW_CLK_HZ = 125000000;
  localparam int unsigned BSW_SHIP_DLY_MS = 10000;
  localparam int unsigned BSW_DEGLITCH_MS = 1;
  localparam int unsigned BSW_RST_HOLD_MS = 10000;
  localparam int unsigned BSW_RST_OFF_MS = 250;
  localparam int unsigned BSW_BLINK_HZ = 1;
  localparam int unsigned BSW_SHIP_DLY_CYC = BSW_SHIP_DLY_MS * (BSW_CLK_HZ / 1000);
  localparam int unsigned BSW_DEGLITCH_CYC = BSW_DEGLITCH_MS * (BSW_CLK_HZ / 1000);
  localparam int unsigned BSW_RST_HOLD_CYC = BSW_RST_HOLD_MS * (BSW_CLK_HZ / 1000);
  localparam int unsigned BSW_RST_OFF_CYC = BSW_RST_OFF_MS * (BSW_CLK_HZ / 1000);
  localparam int unsigned BSW_BLINK_HALF_CYC = BSW_CLK_HZ / (2 * BSW_BLINK_HZ);

  ////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [1:0] {
    BSW_ST_ON = 2'b00,
    BSW_ST_SHIP_WAIT = 2'b01,
    BSW_ST_SHIP = 2'b10,
    BSW_ST_RST_OFF = 2'b11
  } bsw_state_t;

  typedef struct packed {
    logic [1:0] charge_monitor_field;
    logic regrst;
    logic button_reset_enable_bit;
    logic shipping_delay_bit;
    logic battery_switch_disable_bit;
  } bsw_ctrl_t;

  typedef struct packed {
    logic [1:0] state;
    logic ship_mode;
    logic switch_on;
    logic supplement;
    logic power_good_flag;
    logic input_current_limit_flag;
    logic input_voltage_limit_flag;
    logic min_system_regulation_flag;
  } bsw_status_t;

  typedef struct packed {
    logic adapter_present;
    logic pg_above_uvlo;
    logic pg_above_bat;
    logic pg_below_ovp;
    logic pg_load_ok;
    logic pg_detect_done;
    logic sys_at_min;
    logic input_voltage_limit;
    logic input_current_limit;
    logic bat_above_min;
    logic sys_drop_180;
    logic sys_drop_45;
    logic bat_depleted;
    logic charging;
    logic charge_done;
    logic sleep_mode;
    logic charge_disabled;
    logic susp_ovp;
    logic susp_ts;
    logic susp_timer;
    logic susp_sysovp;
    logic boost_ts_fault;
  } bsw_sense_t;

endpackage : bsw_pkg

//--- bsw_sync.sv
`timescale 1ns/10ps
module bsw_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Levels.
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  import bsw_pkg::*;

  logic [W-1:0] meta;

  // Two-stage synchroniser; only the second stage reads the first.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule : bsw_sync

//--- bsw_timer.sv
`timescale 1ns/10ps
module bsw_timer #(
  parameter int W = 32
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Control.
  input wire logic run,
  input wire logic [W-1:0] limit,
  // Elapsed cycles, saturating at the limit.
  output logic [W-1:0] count
);
  import bsw_pkg::*;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else if (!run) begin
      count <= '0;
    end else if (count != limit) begin
      count <= count + 1'b1;
    end
  end

endmodule : bsw_timer

//--- bsw_button_model.sv
`timescale 1ns/10ps
module bsw_button_model (
  // Indicator pin.
  input wire logic stat_out,
  input wire logic stat_oe_n,
  output logic led_pin,
  // Push button.
  output logic push_button_input
);
  logic pressed = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // An open contact is pulled up, and the indicator line is pulled up through the LED.
  assign push_button_input = pressed ? 1'b0 : 1'b1;
  assign led_pin = stat_oe_n ? 1'b1 : stat_out;

  task press(input logic down);
    pressed <= down;
  endtask : press
endmodule : bsw_button_model

//--- bsw_top_bench.sv
`timescale 1ns/10ps
module bsw_top_bench;
  import bsw_pkg::*;
  localparam int SHIP = 20;
  localparam int DEG = 5;
  localparam int HOLD = 40;
  localparam int OFF = 10;
  localparam int HALF = 8;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, err, push_button_input, led_pin;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic battery_switch_on, supplement_mode, charge_reduce, power_good_pin_n, stat_out, stat_oe_n, irq;
  bsw_sense_t sense;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  int n, ones;

  bsw_top #(.SHIP_DLY_CYC(SHIP), .DEGLITCH_CYC(DEG), .RST_HOLD_CYC(HOLD), .RST_OFF_CYC(OFF),
    .BLINK_HALF_CYC(HALF)) u_bsw_top (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sense(sense), .push_button_input(push_button_input), .battery_switch_on(battery_switch_on),
    .supplement_mode(supplement_mode), .charge_reduce(charge_reduce), .power_good_pin_n(power_good_pin_n),
    .stat_out(stat_out), .stat_oe_n(stat_oe_n), .irq(irq));

  bsw_button_model u_bsw_button_model (.stat_out(stat_out), .stat_oe_n(stat_oe_n), .led_pin(led_pin),
    .push_button_input(push_button_input));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  task end_sim();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick

  // One APB transfer; holds the request until pready is seen high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wait_sw(input logic v, output int c);
    c = 0;
    while (battery_switch_on !== v && c < 100) begin
      @(posedge clk);
      c++;
    end
  endtask : wait_sw

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sense = '0;
    tick(6);
    reset_n <= 1'b1;
    tick(3);
    apb(1'b0, BSW_CTRL_OFS, 32'h0);
    chk(rd, 32'h4);
    apb(1'b0, BSW_INT_MASK_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    chk(battery_switch_on, 1'b1);
    apb(1'b1, BSW_INT_MASK_OFS, 32'h1f);
    sense.pg_above_uvlo <= 1'b1;
    sense.pg_above_bat <= 1'b1;
    sense.pg_below_ovp <= 1'b1;
    sense.pg_load_ok <= 1'b1;
    tick(5);
    chk(power_good_pin_n, 1'b1);
    sense.pg_detect_done <= 1'b1;
    tick(5);
    chk(power_good_pin_n, 1'b0);
    apb(1'b0, BSW_STATUS_OFS, 32'h0);
    chk(rd[3], 1'b1);
    chk(irq, 1'b1);
    apb(1'b1, BSW_INT_STATUS_OFS, 32'h1f);
    tick(2);
    chk(irq, 1'b0);
    sense.sys_at_min <= 1'b1;
    sense.input_voltage_limit <= 1'b1;
    tick(5);
    chk(charge_reduce, 1'b1);
    apb(1'b0, BSW_STATUS_OFS, 32'h0);
    chk(rd[2:0], 3'b011);
    sense.sys_at_min <= 1'b0;
    sense.input_voltage_limit <= 1'b0;
    sense.input_current_limit <= 1'b1;
    apb(1'b1, BSW_INT_MASK_OFS, 32'h0);
    tick(5);
    chk(irq, 1'b0);
    apb(1'b0, BSW_STATUS_OFS, 32'h0);
    chk(rd[2:0], 3'b100);
    chk(charge_reduce, 1'b1);
    apb(1'b0, BSW_INT_STATUS_OFS, 32'h0);
    chk(rd[3], 1'b1);
    sense.input_current_limit <= 1'b0;
    apb(1'b1, BSW_INT_STATUS_OFS, 32'h1f);
    apb(1'b1, BSW_INT_MASK_OFS, 32'h1f);
    tick(3);
    chk({charge_reduce, irq}, 2'b00);
    apb(1'b1, BSW_CTRL_OFS, 32'h5);
    tick(2);
    chk(battery_switch_on, 1'b0);
    sense.adapter_present <= 1'b1;
    wait_sw(1'b1, n);
    chk(n < 8, 1'b1);
    apb(1'b0, BSW_CTRL_OFS, 32'h0);
    chk(rd, 32'h4);
    sense.adapter_present <= 1'b0;
    apb(1'b1, BSW_CTRL_OFS, 32'h7);
    tick(SHIP - 4);
    chk(battery_switch_on, 1'b1);
    wait_sw(1'b0, n);
    chk(n < 10, 1'b1);
    apb(1'b1, BSW_CTRL_OFS, 32'h4);
    wait_sw(1'b1, n);
    chk(n < 5, 1'b1);
    apb(1'b1, BSW_CTRL_OFS, 32'h5);
    apb(1'b1, BSW_INT_STATUS_OFS, 32'h1f);
    u_bsw_button_model.press(1'b1);
    tick(DEG - 2);
    u_bsw_button_model.press(1'b0);
    tick(6);
    chk(battery_switch_on, 1'b0);
    u_bsw_button_model.press(1'b1);
    wait_sw(1'b1, n);
    chk(n >= DEG && n < DEG + 6, 1'b1);
    u_bsw_button_model.press(1'b0);
    apb(1'b0, BSW_INT_STATUS_OFS, 32'h0);
    chk({rd[1], irq}, 2'b11);
    apb(1'b1, BSW_INT_STATUS_OFS, 32'h1f);
    u_bsw_button_model.press(1'b1);
    wait_sw(1'b0, n);
    chk(n >= HOLD && n < HOLD + 6, 1'b1);
    wait_sw(1'b1, n);
    chk(n, OFF + 1);
    u_bsw_button_model.press(1'b0);
    apb(1'b0, BSW_INT_STATUS_OFS, 32'h0);
    chk(rd[2], 1'b1);
    apb(1'b1, BSW_CTRL_OFS, 32'h0);
    u_bsw_button_model.press(1'b1);
    wait_sw(1'b0, n);
    chk(n, 100);
    u_bsw_button_model.press(1'b0);
    apb(1'b1, BSW_CTRL_OFS, 32'h5);
    tick(2);
    chk(battery_switch_on, 1'b0);
    apb(1'b1, BSW_CTRL_OFS, 32'h8);
    wait_sw(1'b1, n);
    chk(n < 5, 1'b1);
    apb(1'b0, BSW_CTRL_OFS, 32'h0);
    chk(rd, 32'h4);
    sense.charging <= 1'b1;
    tick(5);
    chk(led_pin, 1'b0);
    for (int i = 0; i < 5; i++) begin
      sense.susp_ovp <= (i == 0);
      sense.susp_ts <= (i == 1);
      sense.susp_timer <= (i == 2);
      sense.susp_sysovp <= (i == 3);
      sense.boost_ts_fault <= (i == 4);
      tick(5);
      ones = 0;
      repeat (4 * HALF) begin
        @(posedge clk);
        ones += int'(stat_oe_n);
      end
      chk(ones, 2 * HALF);
    end
    sense[4:0] <= 5'h00;
    sense.charging <= 1'b0;
    sense.charge_done <= 1'b1;
    tick(5);
    chk(led_pin, 1'b1);
    sense.charge_done <= 1'b0;
    sense.charging <= 1'b1;
    sense.sleep_mode <= 1'b1;
    tick(5);
    chk(led_pin, 1'b1);
    sense.sleep_mode <= 1'b0;
    sense.charge_disabled <= 1'b1;
    tick(5);
    chk(led_pin, 1'b1);
    sense.charge_disabled <= 1'b0;
    tick(5);
    chk(led_pin, 1'b0);
    apb(1'b1, BSW_CTRL_OFS, 32'h34);
    tick(3);
    chk(stat_oe_n, 1'b1);
    sense.bat_above_min <= 1'b1;
    sense.sys_drop_45 <= 1'b1;
    tick(5);
    chk(supplement_mode, 1'b0);
    sense.sys_drop_180 <= 1'b1;
    tick(5);
    chk(supplement_mode, 1'b1);
    apb(1'b0, BSW_STATUS_OFS, 32'h0);
    chk(rd[4], 1'b1);
    sense.bat_depleted <= 1'b1;
    tick(5);
    chk({supplement_mode, battery_switch_on}, 2'b00);
    sense.bat_depleted <= 1'b0;
    sense.bat_above_min <= 1'b0;
    sense.sys_drop_180 <= 1'b0;
    tick(5);
    chk({supplement_mode, battery_switch_on}, 2'b11);
    end_sim();
  end
endmodule : bsw_top_bench
